//--- include/alsup_pkg.sv
// package: constants and carrier types for the axis limit supervisor
package alsup_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned OT_SAMPLE_MS = 10;
    localparam int unsigned OT_SAMPLE_CYC = CLK_HZ / 1000 * OT_SAMPLE_MS;
    localparam int unsigned MS_CYC = CLK_HZ / 1000;

    // ------------------------------------------------------------
    // codes and bounds
    // ------------------------------------------------------------
    localparam logic [15:0] SYNTH_MOTOR = 16'hffff;
    localparam logic [63:0] MAX_POS_COUNTS = 64'h0000_0009_502f_9000;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_OT_POS = 8'h01;
    localparam logic [7:0] ERR_OT_NEG = 8'h02;
    localparam logic [7:0] ERR_BOUND_HI = 8'h03;
    localparam logic [7:0] ERR_BOUND_LO = 8'h04;
    localparam logic [7:0] ERR_BOUND_ADJ = 8'h17;
    localparam logic [7:0] ERR_VEL = 8'h20;
    localparam logic [7:0] ERR_ACC = 8'h21;
    localparam logic [7:0] ERR_DEC = 8'h22;
    localparam logic [7:0] ERR_JERK = 8'h23;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ALSUP_SRC_JOG,
        ALSUP_SRC_PROG,
        ALSUP_SRC_FOLLOW,
        ALSUP_SRC_MOVEVEL
    } alsup_src_t;

    typedef struct packed {
        logic ot_enable;
        logic pos_assigned;
        logic neg_assigned;
        logic dir_reverse;
        logic bound_enable;
        logic [15:0] motor_type;
        logic [15:0] disable_delay_ms;
    } alsup_cfg_t;

    typedef struct packed {
        logic signed [31:0] max_vel;
        logic signed [31:0] max_acc;
        logic signed [31:0] max_dec;
        logic signed [31:0] max_jerk;
    } alsup_lim_t;

    typedef struct packed {
        logic valid;
        alsup_src_t src;
        logic signed [63:0] target;
    } alsup_cmd_t;

endpackage

//--- src/alsup_slew.sv
// velocity clamp and acceleration, deceleration and jerk limiter
`timescale 1ns/1ps
`default_nettype none
module alsup_slew #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // control
    input wire logic i_tick,
    input wire logic i_zero,
    input wire logic signed [W-1:0] i_sum,
    input wire alsup_pkg::alsup_lim_t i_lim,
    // result
    output logic signed [W-1:0] o_vel,
    output logic [7:0] o_err,
    output logic o_err_stb
);

    logic signed [W-1:0] vel_q, vel_d, acc_q, acc_d;
    logic [7:0] err_q, err_d;
    logic stb_q, stb_d;

    function automatic logic signed [W-1:0] clip(
        input logic signed [W-1:0] v,
        input logic signed [W-1:0] lim
    );
        if (v > lim)
            return lim;
        if (v < -lim)
            return -lim;
        return v;
    endfunction

    always_comb
    begin
        logic signed [W-1:0] want, step, dstep;
        want = '0;
        step = '0;
        dstep = '0;
        vel_d = vel_q;
        acc_d = acc_q;
        err_d = err_q;
        stb_d = 1'b0;
        if (i_zero)
        begin
            // trip stops dead, no ramp is wanted
            vel_d = '0;
            acc_d = '0;
        end
        else if (i_tick)
        begin
            want = clip(i_sum, i_lim.max_vel);
            if (want != i_sum)
            begin
                err_d = alsup_pkg::ERR_VEL;
                stb_d = 1'b1;
            end
            step = want - vel_q;
            if (step > i_lim.max_acc)
            begin
                step = i_lim.max_acc;
                err_d = alsup_pkg::ERR_ACC;
                stb_d = 1'b1;
            end
            else if (step < -i_lim.max_dec)
            begin
                step = -i_lim.max_dec;
                err_d = alsup_pkg::ERR_DEC;
                stb_d = 1'b1;
            end
            dstep = step - acc_q;
            if (dstep > i_lim.max_jerk || dstep < -i_lim.max_jerk)
            begin
                step = acc_q + clip(dstep, i_lim.max_jerk);
                err_d = alsup_pkg::ERR_JERK;
                stb_d = 1'b1;
            end
            // jerk clamp may pull past the velocity limit, so clip again
            vel_d = clip(vel_q + step, i_lim.max_vel);
            acc_d = vel_d - vel_q;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            vel_q <= '0;
            acc_q <= '0;
            err_q <= alsup_pkg::ERR_NONE;
            stb_q <= 1'b0;
        end
        else
        begin
            vel_q <= vel_d;
            acc_q <= acc_d;
            err_q <= err_d;
            stb_q <= stb_d;
        end
    end

    assign o_vel = vel_q;
    assign o_err = err_q;
    assign o_err_stb = stb_q;

    vel_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(i_tick) && !$past(i_zero) |-> o_vel <= $past(i_lim.max_vel))
        else $error("velocity above limit");
    zero_stop_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_zero |=> o_vel == 0)
        else $error("velocity not zeroed");
    acc_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_tick && !i_zero |=> o_vel - $past(o_vel) <= $past(i_lim.max_acc))
        else $error("acceleration above limit");
    dec_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_tick && !i_zero |=> $past(o_vel) - o_vel <= $past(i_lim.max_dec))
        else $error("deceleration above limit");

endmodule
`default_nettype wire

//--- src/alsup_top.sv
// axis limit supervisor: over-travel, travel bounds, slew, disable delay
// Notes on behaviour
// - checking off: limit inputs become general inputs
// - checking on: sample limits every 10 ms enabled
// - open switch zeroes velocity at once
// - enable relay stays closed until enable cleared
// - trip writes limit code, enters fault halt
// - in fault halt only jog is accepted
// - synthetic motor 65535 skips over-travel checking
// - unassigned switch counts as always tripped
// - direction normal: ccw positive; reverse: cw
// - bounds off: use plus/minus 4E10 counts scaled
// - target above high bound errors, no move
// - target below low bound errors, no move
// - bounds only for jog and program moves
// - high bound clamped to range top, 0x17
// - low bound clamped to low limit, 0x17
// - fault halt jog ignores both bounds
// - clamp summed velocity to maximum, report
// - limit velocity increase to max acceleration
// - limit velocity decrease to max deceleration
// - limit acceleration change to max jerk
// - enable dropped in run: wait disable delay before disabled state
`timescale 1ns/1ps
`default_nettype none
module alsup_top #(
    parameter int unsigned SAMPLE_CYC = alsup_pkg::OT_SAMPLE_CYC,
    parameter int unsigned MS_CYC = alsup_pkg::MS_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // configuration
    input wire alsup_pkg::alsup_cfg_t i_cfg,
    input wire alsup_pkg::alsup_lim_t i_lim,
    input wire logic signed [63:0] i_uu_per_cnt,
    input wire logic signed [63:0] i_bound_hi,
    input wire logic signed [63:0] i_bound_lo,
    input wire logic signed [63:0] i_low_pos_limit,
    input wire logic signed [63:0] i_pos_range,
    // software control
    input wire logic i_drive_enable,
    input wire logic i_err_clear,
    input wire logic i_sample_tick,
    // motion commands
    input wire alsup_pkg::alsup_cmd_t i_cmd,
    input wire logic signed [31:0] i_vel_path,
    input wire logic signed [31:0] i_vel_follow,
    // limit switch pins
    input wire logic i_ot_pos_pin,
    input wire logic i_ot_neg_pin,
    // outputs
    output logic o_cmd_accept,
    output logic o_cmd_reject,
    output logic signed [31:0] o_servo_vel,
    output logic o_relay_closed,
    output logic o_drive_enabled,
    output logic o_fault_halt,
    output logic [7:0] o_err_code,
    output logic o_bound_adj,
    output logic [1:0] o_gp_inputs
);

    typedef enum logic [1:0] {
        ALSUP_DISABLED,
        ALSUP_RUN,
        ALSUP_STOPPING,
        ALSUP_HALT
    } alsup_state_t;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync1_q, sync2_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
        end
        else
        begin
            sync1_q <= {i_ot_pos_pin, i_ot_neg_pin};
            sync2_q <= sync1_q;
        end
    end

    // direction reverse swaps which physical switch guards positive travel
    logic sw_pos, sw_neg;
    assign sw_pos = i_cfg.dir_reverse ? sync2_q[0] : sync2_q[1];
    assign sw_neg = i_cfg.dir_reverse ? sync2_q[1] : sync2_q[0];
    assign o_gp_inputs = i_cfg.ot_enable ? 2'h0 : sync2_q;

    // ------------------------------------------------------------
    // travel bounds
    // ------------------------------------------------------------
    logic signed [63:0] hi_eff, lo_eff, range_top, max_uu;
    logic hi_adj, lo_adj;

    always_comb
    begin
        max_uu = 64'(signed'(alsup_pkg::MAX_POS_COUNTS) * i_uu_per_cnt);
        range_top = i_low_pos_limit + i_pos_range;
        hi_adj = 1'b0;
        lo_adj = 1'b0;
        if (!i_cfg.bound_enable)
        begin
            hi_eff = max_uu;
            lo_eff = -max_uu;
        end
        else
        begin
            hi_eff = i_bound_hi;
            lo_eff = i_bound_lo;
            if (i_bound_hi > range_top)
            begin
                hi_eff = range_top;
                hi_adj = 1'b1;
            end
            if (i_bound_lo < i_low_pos_limit)
            begin
                lo_eff = i_low_pos_limit;
                lo_adj = 1'b1;
            end
        end
    end

    assign o_bound_adj = hi_adj | lo_adj;

    // ------------------------------------------------------------
    // sample counter and axis state
    // ------------------------------------------------------------
    alsup_state_t state_q, state_d;
    logic [31:0] smp_q, smp_d;
    logic [31:0] dly_q, dly_d;
    logic [15:0] ms_q, ms_d;
    logic [7:0] err_q, err_d;
    logic relay_q, relay_d;
    logic acc_q, acc_d, rej_q, rej_d;
    logic check_on, sample_now, trip, trip_pos;
    logic is_jog, bounded, over_hi, under_lo;
    logic [7:0] slew_err;
    logic slew_stb;

    assign check_on = i_cfg.ot_enable
        && i_cfg.motor_type != alsup_pkg::SYNTH_MOTOR;
    assign sample_now = smp_q == SAMPLE_CYC - 1;
    // an unassigned switch reads tripped, so the axis trips at its first sample in run
    assign trip_pos = !sw_pos || !i_cfg.pos_assigned;
    assign trip = check_on && (state_q == ALSUP_RUN) && sample_now
        && (trip_pos || !sw_neg || !i_cfg.neg_assigned);
    assign is_jog = i_cmd.src == alsup_pkg::ALSUP_SRC_JOG;
    assign bounded = (i_cmd.src == alsup_pkg::ALSUP_SRC_JOG
        || i_cmd.src == alsup_pkg::ALSUP_SRC_PROG)
        && !(state_q == ALSUP_HALT && is_jog);
    assign over_hi = bounded && i_cmd.target > hi_eff;
    assign under_lo = bounded && i_cmd.target < lo_eff;

    always_comb
    begin
        state_d = state_q;
        err_d = err_q;
        relay_d = relay_q;
        dly_d = dly_q;
        ms_d = ms_q;
        acc_d = 1'b0;
        rej_d = 1'b0;
        smp_d = sample_now ? 32'h0 : smp_q + 32'h1;
        if (!check_on || state_q != ALSUP_RUN)
            smp_d = 32'h0;
        if (slew_stb && state_q != ALSUP_HALT)
            err_d = slew_err;
        if (o_bound_adj && state_q != ALSUP_HALT)
            err_d = alsup_pkg::ERR_BOUND_ADJ;
        case (state_q)
            ALSUP_DISABLED:
            begin
                relay_d = 1'b0;
                if (i_drive_enable)
                begin
                    state_d = ALSUP_RUN;
                    relay_d = 1'b1;
                end
            end
            ALSUP_RUN:
            begin
                if (trip)
                begin
                    err_d = trip_pos ? alsup_pkg::ERR_OT_POS
                        : alsup_pkg::ERR_OT_NEG;
                    state_d = ALSUP_HALT;
                end
                else if (!i_drive_enable)
                begin
                    state_d = ALSUP_STOPPING;
                    dly_d = 32'(i_cfg.disable_delay_ms);
                    ms_d = 16'h0;
                end
            end
            ALSUP_STOPPING:
            begin
                if (ms_q == 16'(MS_CYC - 1))
                begin
                    ms_d = 16'h0;
                    if (dly_q != 32'h0)
                        dly_d = dly_q - 32'h1;
                end
                else
                    ms_d = ms_q + 16'h1;
                if (dly_q == 32'h0)
                begin
                    state_d = ALSUP_DISABLED;
                    relay_d = 1'b0;
                end
            end
            ALSUP_HALT:
            begin
                // relay held closed until software drops the enable
                if (!i_drive_enable && relay_q)
                begin
                    dly_d = 32'(i_cfg.disable_delay_ms);
                    ms_d = 16'h0;
                    relay_d = 1'b0;
                end
                else if (!relay_q)
                begin
                    if (ms_q == 16'(MS_CYC - 1))
                    begin
                        ms_d = 16'h0;
                        if (dly_q != 32'h0)
                            dly_d = dly_q - 32'h1;
                    end
                    else
                        ms_d = ms_q + 16'h1;
                end
                if (i_err_clear)
                begin
                    err_d = alsup_pkg::ERR_NONE;
                    state_d = i_drive_enable ? ALSUP_RUN : ALSUP_DISABLED;
                    relay_d = i_drive_enable;
                end
            end
            default:
                state_d = ALSUP_DISABLED;
        endcase
        if (i_cmd.valid)
        begin
            if ((state_q == ALSUP_HALT && !is_jog) || over_hi || under_lo
                || state_q == ALSUP_DISABLED)
            begin
                rej_d = 1'b1;
                if (over_hi && state_d != ALSUP_HALT)
                    err_d = alsup_pkg::ERR_BOUND_HI;
                else if (under_lo && state_d != ALSUP_HALT)
                    err_d = alsup_pkg::ERR_BOUND_LO;
            end
            else
                acc_d = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            state_q <= ALSUP_DISABLED;
            err_q <= alsup_pkg::ERR_NONE;
            relay_q <= 1'b0;
            dly_q <= 32'h0;
            ms_q <= 16'h0;
            smp_q <= 32'h0;
            acc_q <= 1'b0;
            rej_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            err_q <= err_d;
            relay_q <= relay_d;
            dly_q <= dly_d;
            ms_q <= ms_d;
            smp_q <= smp_d;
            acc_q <= acc_d;
            rej_q <= rej_d;
        end
    end

    // ------------------------------------------------------------
    // velocity path
    // ------------------------------------------------------------
    logic stop_vel;
    assign stop_vel = trip || state_q != ALSUP_RUN;

    alsup_slew #(
        .W(32)
    ) u_slew (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tick(i_sample_tick),
        .i_zero(stop_vel),
        .i_sum(i_vel_path + i_vel_follow),
        .i_lim(i_lim),
        .o_vel(o_servo_vel),
        .o_err(slew_err),
        .o_err_stb(slew_stb)
    );

    assign o_cmd_accept = acc_q;
    assign o_cmd_reject = rej_q;
    assign o_relay_closed = relay_q;
    assign o_drive_enabled = state_q != ALSUP_DISABLED;
    assign o_fault_halt = state_q == ALSUP_HALT;
    assign o_err_code = err_q;

    halt_holds_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_fault_halt && !i_err_clear |=> o_fault_halt)
        else $error("fault halt left without clear");
    relay_held_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_fault_halt && i_drive_enable && relay_q |=> relay_q)
        else $error("relay opened while enabled");
    trip_code_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        trip |=> o_fault_halt && (o_err_code == alsup_pkg::ERR_OT_POS
        || o_err_code == alsup_pkg::ERR_OT_NEG))
        else $error("trip without code");
    halt_reject_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_cmd.valid && o_fault_halt && !is_jog |=> o_cmd_reject)
        else $error("non-jog taken in halt");
    synth_skip_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_cfg.motor_type == alsup_pkg::SYNTH_MOTOR |-> !trip)
        else $error("synthetic motor tripped");
    bound_rej_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_cmd.valid && (over_hi || under_lo) |=> o_cmd_reject)
        else $error("out of bound target taken");
    sample_gap_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        trip |-> smp_q == SAMPLE_CYC - 1)
        else $error("trip off sample");
    delay_end_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_q == ALSUP_STOPPING && dly_q != 0 |=> o_drive_enabled)
        else $error("disabled before delay");

    trip_c: cover property (@(posedge i_sys_clk) trip);
    clear_c: cover property (@(posedge i_sys_clk) o_fault_halt && i_err_clear);
    stop_c: cover property (@(posedge i_sys_clk)
        state_q == ALSUP_STOPPING ##1 state_q == ALSUP_DISABLED);

endmodule
`default_nettype wire

//--- sim/alsup_partner.sv
// partner model: axis limit switch contacts and servo amplifier
`timescale 1ns/1ps
`default_nettype none
module alsup_partner (
    // clock
    input wire logic i_sys_clk,
    // from the supervisor
    input wire logic i_relay_closed,
    input wire logic signed [31:0] i_servo_vel,
    // bench control of the switch actuators
    input wire logic i_open_pos,
    input wire logic i_open_neg,
    // switch pins and shaft position
    output logic o_ot_pos_pin,
    output logic o_ot_neg_pin,
    output logic signed [63:0] o_shaft_pos
);
    initial o_shaft_pos = 64'sh0;
    // the amplifier only turns the shaft while its relay is closed
    always @(posedge i_sys_clk)
        if (i_relay_closed)
            o_shaft_pos <= o_shaft_pos + 64'(i_servo_vel);
    // fail-safe contacts: an open switch reads logic zero
    assign o_ot_pos_pin = !i_open_pos;
    assign o_ot_neg_pin = !i_open_neg;
endmodule
`default_nettype wire

//--- sim/axis_limit_supervisor_bench.sv
// testbench: commands, limit pins and slew traffic for the supervisor
`timescale 1ns/1ps
`default_nettype none
module axis_limit_supervisor_bench;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic sys_clk, rst, drv_en, err_clr, tick, open_pos, open_neg;
    logic pos_pin, neg_pin, acc, rej, relay, den, halt, badj;
    alsup_pkg::alsup_cfg_t cfg;
    alsup_pkg::alsup_lim_t lim;
    alsup_pkg::alsup_cmd_t cmd;
    logic signed [63:0] uu, bhi, blo, lpl, prng;
    logic signed [31:0] vpath, vfol, svel;
    logic [7:0] ecode;
    logic [1:0] gp;
    int mismatches, compares, cyc;

    alsup_top #(.SAMPLE_CYC(20), .MS_CYC(4)) u_dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_cfg(cfg), .i_lim(lim),
        .i_uu_per_cnt(uu), .i_bound_hi(bhi), .i_bound_lo(blo),
        .i_low_pos_limit(lpl), .i_pos_range(prng),
        .i_drive_enable(drv_en), .i_err_clear(err_clr),
        .i_sample_tick(tick), .i_cmd(cmd), .i_vel_path(vpath),
        .i_vel_follow(vfol), .i_ot_pos_pin(pos_pin),
        .i_ot_neg_pin(neg_pin), .o_cmd_accept(acc), .o_cmd_reject(rej),
        .o_servo_vel(svel), .o_relay_closed(relay),
        .o_drive_enabled(den), .o_fault_halt(halt), .o_err_code(ecode),
        .o_bound_adj(badj), .o_gp_inputs(gp)
    );
    alsup_partner u_partner (
        .i_sys_clk(sys_clk), .i_relay_closed(relay), .i_servo_vel(svel),
        .i_open_pos(open_pos), .i_open_neg(open_neg),
        .o_ot_pos_pin(pos_pin), .o_ot_neg_pin(neg_pin), .o_shaft_pos()
    );

    always #25 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk_bit(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t flag got %b exp %b", $time, g, e);
        end
    endtask
    task automatic chk_code(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t code got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_vel(input logic signed [31:0] g,
                           input logic signed [31:0] e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t velocity got %0d exp %0d", $time, g, e);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // answer stands exactly one cycle, one cycle after the request
    task automatic send(input alsup_pkg::alsup_src_t s,
                        input logic signed [63:0] t, input logic e);
        cmd = '{1'b1, s, t};
        step(1);
        cmd.valid = 1'b0;
        chk_bit(acc, e);
        chk_bit(rej, !e);
        step(1);
        chk_bit(acc | rej, 1'b0);
    endtask
    // sum is split across both sources so only their total matters
    task automatic slew(input logic signed [31:0] s,
                        input logic signed [31:0] ev, input logic [7:0] ec);
        vpath = s - 32'sh7;
        vfol = 32'sh7;
        tick = 1'b1;
        step(1);
        tick = 1'b0;
        step(1);
        chk_vel(svel, ev);
        chk_code(ecode, ec);
    endtask
    task automatic wait_halt(input int n);
        for (int i = 0; i < n && halt !== 1'b1; i++)
            step(1);
        chk_bit(halt, 1'b1);
    endtask
    task automatic recover;
        drv_en = 1'b0;
        open_pos = 1'b0;
        open_neg = 1'b0;
        step(3);
        err_clr = 1'b1;
        step(1);
        err_clr = 1'b0;
        step(3);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            give_verdict;
        end
    end

    initial
    begin
        sys_clk = 1'b0; rst = 1'b1; drv_en = 1'b0; err_clr = 1'b0;
        tick = 1'b0; open_pos = 1'b0; open_neg = 1'b0; cmd = '0;
        cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0001, 16'h0003};
        lim = '{32'sh64, 32'sha, 32'sh14, 32'sh3e8};
        uu = 64'sh1; bhi = 64'sh3e8; blo = -64'sh3e8;
        lpl = -64'sh2e_90ed_d000; prng = 64'sh5d_21db_a000;
        vpath = 32'sh0; vfol = 32'sh0;
        mismatches = 0; compares = 0; cyc = 0;
        step(4);
        rst = 1'b0;
        step(3);
        chk_vel(svel, 32'sh0);
        chk_bit(relay, 1'b0);
        send(alsup_pkg::ALSUP_SRC_JOG, 64'sh0, 1'b0);
        cfg.ot_enable = 1'b0;
        open_pos = 1'b1;
        step(4);
        chk_code({6'h00, gp}, 8'h01);
        open_pos = 1'b0;
        cfg.ot_enable = 1'b1;
        step(4);
        chk_code({6'h00, gp}, 8'h00);
        drv_en = 1'b1;
        step(3);
        chk_bit(relay, 1'b1);
        send(alsup_pkg::ALSUP_SRC_PROG, 64'sh3e8, 1'b1);
        send(alsup_pkg::ALSUP_SRC_PROG, 64'sh3e9, 1'b0);
        chk_code(ecode, alsup_pkg::ERR_BOUND_HI);
        send(alsup_pkg::ALSUP_SRC_JOG, -64'sh3e9, 1'b0);
        chk_code(ecode, alsup_pkg::ERR_BOUND_LO);
        send(alsup_pkg::ALSUP_SRC_FOLLOW, 64'sh2328, 1'b1);
        send(alsup_pkg::ALSUP_SRC_MOVEVEL, -64'sh2328, 1'b1);
        cfg.bound_enable = 1'b0;
        uu = 64'sh2;
        step(2);
        send(alsup_pkg::ALSUP_SRC_PROG, alsup_pkg::MAX_POS_COUNTS * 2,
             1'b1);
        send(alsup_pkg::ALSUP_SRC_PROG, alsup_pkg::MAX_POS_COUNTS * 2 + 1,
             1'b0);
        cfg.bound_enable = 1'b1;
        bhi = lpl + prng + 64'sh1;
        step(2);
        chk_bit(badj, 1'b1);
        chk_code(ecode, alsup_pkg::ERR_BOUND_ADJ);
        bhi = 64'sh3e8;
        blo = lpl - 64'sh1;
        step(2);
        chk_bit(badj, 1'b1);
        chk_code(ecode, alsup_pkg::ERR_BOUND_ADJ);
        blo = -64'sh3e8;
        step(2);
        for (int i = 1; i <= 5; i++)
            slew(32'sh32, 32'(10 * i), alsup_pkg::ERR_ACC);
        slew(32'sh32, 32'sh32, alsup_pkg::ERR_ACC);
        slew(32'sh0, 32'sh1e, alsup_pkg::ERR_DEC);
        lim.max_acc = 32'sh3e8;
        lim.max_dec = 32'sh3e8;
        slew(32'sh96, 32'sh64, alsup_pkg::ERR_VEL);
        slew(32'sh96, 32'sh64, alsup_pkg::ERR_VEL);
        lim.max_jerk = 32'sh5;
        slew(32'sh0, 32'sh5f, alsup_pkg::ERR_JERK);
        open_pos = 1'b1;
        wait_halt(30);
        chk_vel(svel, 32'sh0);
        chk_code(ecode, alsup_pkg::ERR_OT_POS);
        chk_bit(relay, 1'b1);
        send(alsup_pkg::ALSUP_SRC_PROG, 64'sh0, 1'b0);
        send(alsup_pkg::ALSUP_SRC_JOG, 64'sh7d0, 1'b1);
        step(40);
        chk_bit(halt, 1'b1);
        chk_code(ecode, alsup_pkg::ERR_OT_POS);
        drv_en = 1'b0;
        step(3);
        chk_bit(relay, 1'b0);
        recover;
        chk_bit(halt, 1'b0);
        cfg.dir_reverse = 1'b1;
        drv_en = 1'b1;
        step(3);
        open_neg = 1'b1;
        wait_halt(30);
        chk_code(ecode, alsup_pkg::ERR_OT_POS);
        recover;
        cfg.dir_reverse = 1'b0;
        cfg.motor_type = alsup_pkg::SYNTH_MOTOR;
        drv_en = 1'b1;
        step(3);
        open_pos = 1'b1;
        step(40);
        chk_bit(halt, 1'b0);
        drv_en = 1'b0;
        open_pos = 1'b0;
        step(20);
        cfg.motor_type = 16'h0001;
        cfg.pos_assigned = 1'b0;
        drv_en = 1'b1;
        wait_halt(30);
        recover;
        cfg.pos_assigned = 1'b1;
        drv_en = 1'b1;
        step(3);
        chk_bit(relay, 1'b1);
        drv_en = 1'b0;
        step(8);
        chk_bit(relay, 1'b1);
        chk_bit(den, 1'b1);
        step(12);
        chk_bit(relay, 1'b0);
        chk_bit(den, 1'b0);
        give_verdict;
    end
endmodule
`default_nettype wire
